// file: ctrl_msg_sender.sv
// Network-side sender model: builds control field groups, pulses action time.
// Assumes the bench sets the wanted code and flags on clk.
`timescale 1ns/10ps
module ctrl_msg_sender (
    input  wire logic       clk,
    input  wire logic [2:0] want_code,
    input  wire logic       want_t2t,
    input  wire logic       want_init,
    input  wire logic       fire,
    output logic      [7:0] field,
    output logic            action_time
);
    // Reserved kept zero; only a bench fault case sets it
    assign field = {want_code,
                    3'h0,
                    want_t2t,
                    want_init};
    always_ff @(posedge clk) begin
        action_time <= fire;
    end
endmodule

// file: pcm_ctrl_if.sv
// Carrier between the control core and the PCM sample path.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface pcm_ctrl_if;
    logic       narrowband;
    logic [1:0] precision;
    logic       mute;

    modport ctrl (output narrowband, output precision, output mute);
    modport path (input narrowband, input precision, input mute);
endinterface

// file: pcm_sample_path.sv
// PCM sample path: sample pacing, precision widening and output mute.
// Assumes samples at the pins are synchronous to clk and held between ticks.
`timescale 1ns/10ps
module pcm_sample_path
    import rate_ctrl_pkg::*;
#(
    parameter logic [12:0] NB_DIV_CYCLES = rate_ctrl_pkg::NB_DIV_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset,
    pcm_ctrl_if.path         ctl,
    input  wire logic [15:0] adc_raw,
    input  wire logic [15:0] decoded_sample,
    output logic      [15:0] pcm_in,
    output logic             pcm_in_valid,
    output logic      [15:0] dac_sample,
    output logic             dac_valid
);

    // ------------------------------------------------------------------
    // Widening
    // ------------------------------------------------------------------
    // Narrow samples sit in the low bits; top bits of the pin are ignored
    function automatic logic [15:0] widen(input logic [15:0] x, input logic [1:0] prec);
        case (prec)
            PREC_14: widen = {x[13:0], 2'b00};
            PREC_13: widen = {x[12:0], 3'b000};
            default: widen = x;
        endcase
    endfunction

    logic [12:0] div_cnt;
    logic [12:0] next_div_cnt;
    logic [12:0] div_last;
    logic        tick;
    logic [15:0] next_pcm_in;
    logic [15:0] next_dac_sample;

    // ------------------------------------------------------------------
    // Pacing and sample registers
    // ------------------------------------------------------------------
    always_comb begin
        div_last = ctl.narrowband ? (NB_DIV_CYCLES - 13'h0001) : (WB_DIV_CYCLES - 13'h0001); // [RULE13] [RULE18]
        tick = (div_cnt >= div_last);
        next_div_cnt = tick ? 13'h0000 : (div_cnt + 13'h0001);
        next_pcm_in = tick ? widen(adc_raw, ctl.precision) : pcm_in; // [RULE10] [RULE11] [RULE12]
        next_dac_sample = dac_sample;
        if (tick) begin
            next_dac_sample = ctl.mute ? 16'h0000 : widen(decoded_sample, ctl.precision); // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt      <= 13'h0000;
            pcm_in       <= 16'h0000;
            pcm_in_valid <= 1'b0;
            dac_sample   <= 16'h0000;
            dac_valid    <= 1'b0;
        end else begin
            div_cnt      <= next_div_cnt;
            pcm_in       <= next_pcm_in;
            pcm_in_valid <= tick;
            dac_sample   <= next_dac_sample;
            dac_valid    <= tick;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_widen_low_zero: assert property (@(posedge clk) disable iff (reset) // [RULE11]
        pcm_in_valid && ($past(ctl.precision) == PREC_14) |-> pcm_in[1:0] == 2'b00)
        else $error("Widened sample has nonzero low bits");

    a_wb_spacing: assert property (@(posedge clk) disable iff (reset) // [RULE13]
        pcm_in_valid && !ctl.narrowband && $stable(ctl.narrowband) |=> !pcm_in_valid[*8])
        else $error("Input samples too close together");

    a_paths_paired: assert property (@(posedge clk) disable iff (reset) // [RULE14]
        pcm_in_valid == dac_valid)
        else $error("Input and output sample strobes disagree");

endmodule

// file: rate_ctrl_pkg.sv
// Constants, field layout and register map of the rate and mode control decoder.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package rate_ctrl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          WB_RATE_HZ        = 16_000;
    localparam int          NB_RATE_HZ        = 8_000;
    localparam logic [12:0] WB_DIV_CYCLES     = 13'(CLK_HZ / WB_RATE_HZ);
    localparam logic [12:0] NB_DIV_DEFAULT    = 13'(CLK_HZ / NB_RATE_HZ);
    localparam int          MUTE_TIME_S       = 1;
    localparam logic [25:0] MUTE_DEFAULT      = 26'(CLK_HZ * MUTE_TIME_S);
    localparam int          INIT_LIMIT_MS     = 40;
    localparam int          INIT_LIMIT_CYCLES = (CLK_HZ / 1000) * INIT_LIMIT_MS;
    localparam logic [4:0]  INIT_CYCLES       = 5'h10;

    // ------------------------------------------------------------------
    // Control field group, most significant bit sent first
    // ------------------------------------------------------------------
    localparam int FLD_CODE_HI  = 7;
    localparam int FLD_CODE_LO  = 5;
    localparam int FLD_RSVD_HI  = 4;
    localparam int FLD_RSVD_LO  = 2;
    localparam int FLD_T2T      = 1;
    localparam int FLD_INIT     = 0;
    localparam int CODE_NB_BIT  = 2;
    localparam logic [1:0] CODE_HALF_RATE = 2'h3;
    localparam logic [1:0] MODE_HALF_RATE = 2'h2;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_MSG = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CONFIG   = 8'h08;

    localparam int ST_MODE_LO  = 0;
    localparam int ST_NB       = 2;
    localparam int ST_HR       = 3;
    localparam int ST_T2T      = 4;
    localparam int ST_INIT     = 5;
    localparam int ST_MUTE     = 6;
    localparam int ST_PEND     = 7;
    localparam int ST_CODE_LO  = 8;

    // ------------------------------------------------------------------
    // Reset values and sample precision
    // ------------------------------------------------------------------
    localparam logic [2:0]  RST_CODE   = 3'h0;
    localparam logic [1:0]  RST_MODE   = 2'h0;
    localparam logic [7:0]  RST_FIELD  = 8'h00;
    localparam logic [1:0]  PREC_16    = 2'h0;
    localparam logic [1:0]  PREC_14    = 2'h1;
    localparam logic [1:0]  PREC_13    = 2'h2;
    localparam logic [1:0]  RST_PREC   = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN_INIT = 2'b01,
        ST_LOAD = 2'b11
    } ctrl_state_t;

endpackage

// file: rate_mode_control_decoder.sv
// Rate and mode control decoder with APB register access and PCM sample path.
// Assumes an APB master on clk and an action_time pulse from the system timer.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// [RULE1] Field: code, reserved, terminal flag, init flag
// [RULE2] Codes map to four modes, two bandwidths
// [RULE3] Sender loads code for intended mode
// [RULE4] Sender drives reserved bits zero
// [RULE5] Sender sets terminal flag when needed
// [RULE6] Both flags set mutes audio one second
// [RULE7] Sender clears terminal flag otherwise
// [RULE8] Sender sets init flag to reinitialise
// [RULE9] Sender clears init flag otherwise
// [RULE10] Samples are 16-bit two's complement
// [RULE11] Narrow samples shift left, zero filled
// [RULE12] At least 13 bits resolution kept
// [RULE13] Wideband input samples at 16 kHz
// [RULE14] Wideband output 16-bit at 16 kHz
// [RULE15] Mode held until new code or init
// [RULE16] Init selects mode 0, wideband
// [RULE17] Init completes within 40 ms
// [RULE18] Narrowband uses 8000 Hz both ways
// [RULE19] Reserved ignored; act at action time
module rate_mode_control_decoder
#(
    parameter logic [12:0] NB_DIV_CYCLES = rate_ctrl_pkg::NB_DIV_DEFAULT,
    parameter logic [25:0] MUTE_CYCLES   = rate_ctrl_pkg::MUTE_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        action_time,
    input  wire logic [15:0] adc_raw,
    input  wire logic [15:0] decoded_sample,
    output logic      [1:0]  mode,
    output logic             narrowband,
    output logic             half_rate_ceiling_mode,
    output logic             terminal_to_terminal_flag,
    output logic             codec_init_busy,
    output logic             audio_mute,
    output logic      [15:0] pcm_in,
    output logic             pcm_in_valid,
    output logic      [15:0] dac_sample,
    output logic             dac_valid
);
    import rate_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] code_mode(input logic [2:0] code);
        code_mode = (code[1:0] == CODE_HALF_RATE) ? MODE_HALF_RATE : code[1:0]; // [RULE2]
    endfunction

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] base);
        reg_hit = (addr == base);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ctrl_state_t state;
    ctrl_state_t next_state;
    logic [7:0]  pend_field;
    logic [7:0]  next_pend_field;
    logic        pending;
    logic        next_pending;
    logic [2:0]  cur_code;
    logic [2:0]  next_cur_code;
    logic [2:0]  load_code;
    logic [2:0]  next_load_code;
    logic        mute_req;
    logic        next_mute_req;
    logic [4:0]  init_cnt;
    logic [4:0]  next_init_cnt;
    logic [25:0] mute_cnt;
    logic [25:0] next_mute_cnt;
    logic [1:0]  precision;
    logic [1:0]  next_precision;
    logic [1:0]  next_mode;
    logic        next_narrowband;
    logic        next_hr;
    logic        next_t2t;
    logic        next_init_busy;
    logic        next_audio_mute;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        wr_access;
    logic        wr_msg;
    logic        accept;
    logic        mapped;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Registered answer costs one wait-free access cycle but keeps outputs on flops
    always_comb begin
        mapped = reg_hit(paddr, REG_CTRL_MSG) || reg_hit(paddr, REG_STATUS)
                 || reg_hit(paddr, REG_CONFIG);
        wr_access = psel && penable && pready && pwrite && !pslverr;
        wr_msg = wr_access && reg_hit(paddr, REG_CTRL_MSG);
        status_word = 32'h0000_0000;
        status_word[ST_MODE_LO +: 2] = mode;
        status_word[ST_NB] = narrowband;
        status_word[ST_HR] = half_rate_ceiling_mode;
        status_word[ST_T2T] = terminal_to_terminal_flag;
        status_word[ST_INIT] = codec_init_busy;
        status_word[ST_MUTE] = audio_mute;
        status_word[ST_PEND] = pending;
        status_word[ST_CODE_LO +: 3] = cur_code;
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite && reg_hit(paddr, REG_CTRL_MSG)) begin
                next_prdata = {24'h00_0000, pend_field};
            end else if (!pwrite && reg_hit(paddr, REG_STATUS)) begin
                next_prdata = status_word;
            end else if (!pwrite && reg_hit(paddr, REG_CONFIG)) begin
                next_prdata = {30'h0000_0000, precision};
            end
        end
        next_precision = precision;
        if (wr_access && reg_hit(paddr, REG_CONFIG)) begin
            next_precision = pwdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            precision <= RST_PREC;
        end else begin
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            precision <= next_precision;
        end
    end

    // ------------------------------------------------------------------
    // Message handling
    // ------------------------------------------------------------------
    // One pending message; a later write replaces an unapplied one
    always_comb begin
        accept = pending && action_time && (state == ST_IDLE); // [RULE19]
        next_state = state;
        next_pend_field = pend_field;
        next_pending = pending;
        next_cur_code = cur_code;
        next_load_code = load_code;
        next_mute_req = mute_req;
        next_init_cnt = init_cnt;
        next_mute_cnt = mute_cnt;
        next_t2t = terminal_to_terminal_flag;
        if (accept) begin
            next_pending = 1'b0;
            next_t2t = pend_field[FLD_T2T];
            if (pend_field[FLD_INIT]) begin
                next_state = ST_RUN_INIT;
                next_init_cnt = 5'h00;
                next_cur_code = RST_CODE; // [RULE16]
                next_load_code = pend_field[FLD_CODE_HI:FLD_CODE_LO];
                next_mute_req = pend_field[FLD_T2T];
                next_mute_cnt = 26'h000_0000;
            end else if (pend_field[FLD_CODE_HI:FLD_CODE_LO] != cur_code) begin
                next_cur_code = pend_field[FLD_CODE_HI:FLD_CODE_LO]; // [RULE15]
            end
        end
        case (state)
            ST_IDLE: begin
                // A fresh init cancels any mute still running
                if (mute_cnt != 26'h000_0000 && !(accept && pend_field[FLD_INIT])) begin
                    next_mute_cnt = mute_cnt - 26'h000_0001;
                end
            end
            ST_RUN_INIT: begin
                next_init_cnt = init_cnt + 5'h01;
                if (init_cnt == INIT_CYCLES - 5'h01) begin // [RULE17]
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_cur_code = load_code;
                next_state = ST_IDLE;
                if (mute_req) begin
                    next_mute_cnt = MUTE_CYCLES; // [RULE6]
                end
                next_mute_req = 1'b0;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (wr_msg) begin
            // Write wins over consumption in the same cycle
            next_pend_field = pwdata[7:0]; // [RULE1]
            next_pending = 1'b1;
        end
        // Reserved field plays no part in decoding
        next_mode = code_mode(next_cur_code); // [RULE2] [RULE19]
        next_narrowband = next_cur_code[CODE_NB_BIT];
        next_hr = (next_cur_code[1:0] == CODE_HALF_RATE);
        next_init_busy = (next_state != ST_IDLE);
        next_audio_mute = (next_mute_cnt != 26'h000_0000);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state                     <= ST_IDLE;
            pend_field                <= RST_FIELD;
            pending                   <= 1'b0;
            cur_code                  <= RST_CODE;
            load_code                 <= RST_CODE;
            mute_req                  <= 1'b0;
            init_cnt                  <= 5'h00;
            mute_cnt                  <= 26'h000_0000;
            mode                      <= RST_MODE;
            narrowband                <= 1'b0;
            half_rate_ceiling_mode    <= 1'b0;
            terminal_to_terminal_flag <= 1'b0;
            codec_init_busy           <= 1'b0;
            audio_mute                <= 1'b0;
        end else begin
            state                     <= next_state;
            pend_field                <= next_pend_field;
            pending                   <= next_pending;
            cur_code                  <= next_cur_code;
            load_code                 <= next_load_code;
            mute_req                  <= next_mute_req;
            init_cnt                  <= next_init_cnt;
            mute_cnt                  <= next_mute_cnt;
            mode                      <= next_mode;
            narrowband                <= next_narrowband;
            half_rate_ceiling_mode    <= next_hr;
            terminal_to_terminal_flag <= next_t2t;
            codec_init_busy           <= next_init_busy;
            audio_mute                <= next_audio_mute;
        end
    end

    // ------------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------------
    pcm_ctrl_if pcm_ctl ();

    assign pcm_ctl.narrowband = narrowband;
    assign pcm_ctl.precision  = precision;
    assign pcm_ctl.mute       = audio_mute;

    pcm_sample_path #(
        .NB_DIV_CYCLES (NB_DIV_CYCLES)
    ) u_path (
        .clk            (clk),
        .reset          (reset),
        .ctl            (pcm_ctl),
        .adc_raw        (adc_raw),
        .decoded_sample (decoded_sample),
        .pcm_in         (pcm_in),
        .pcm_in_valid   (pcm_in_valid),
        .dac_sample     (dac_sample),
        .dac_valid      (dac_valid)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_msg_captured: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        wr_msg |=> pending && (pend_field == $past(pwdata[7:0])))
        else $error("Control field write not held as pending");

    a_code_decode: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        accept && !pend_field[FLD_INIT] |=> (narrowband == $past(pend_field[FLD_CODE_HI]))
        && (half_rate_ceiling_mode == ($past(pend_field[6:5]) == CODE_HALF_RATE))
        && (mode == code_mode($past(pend_field[FLD_CODE_HI:FLD_CODE_LO]))))
        else $error("Rate code decoded wrongly");

    a_mode_held: assert property (@(posedge clk) disable iff (reset) // [RULE15]
        !accept && (state == ST_IDLE) |=> $stable(mode) && $stable(narrowband))
        else $error("Mode changed without a message");

    a_init_default: assert property (@(posedge clk) disable iff (reset) // [RULE16]
        accept && pend_field[FLD_INIT] |=> (mode == RST_MODE) && !narrowband
        && codec_init_busy)
        else $error("Init did not select mode 0 wideband");

    a_init_length: assert property (@(posedge clk) disable iff (reset) // [RULE17]
        $rose(codec_init_busy) |-> codec_init_busy [*8] ##[1:10] !codec_init_busy)
        else $error("Init duration out of range");

    a_mute_after_init: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        (state == ST_LOAD) && mute_req |=> audio_mute && !codec_init_busy)
        else $error("Mute did not follow init");

    a_no_mute_plain: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        $rose(audio_mute) |-> $past(state) == ST_LOAD)
        else $error("Mute started outside init completion");

    a_action_only: assert property (@(posedge clk) disable iff (reset) // [RULE19]
        !accept |=> terminal_to_terminal_flag == $past(terminal_to_terminal_flag))
        else $error("Flag changed away from action time");

    a_apb_answer: assert property (@(posedge clk) disable iff (reset)
        psel && !penable |=> pready && (pslverr == !$past(mapped)))
        else $error("APB answer missing");

endmodule

// file: tb_rate_mode_control_decoder.sv
// Testbench of the rate and mode control decoder against a behavioural model.
// Assumes short divider and mute counts so the run stays brief.
`timescale 1ns/10ps
module tb_rate_mode_control_decoder;
    import rate_ctrl_pkg::*;
    localparam logic [12:0] NB_DIV = 13'h0014;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, action_time, fire;
    logic [7:0] paddr, field;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] adc_raw, decoded_sample, pcm_in, dac_sample;
    logic [1:0] mode;
    logic narrowband, half_rate_ceiling_mode, terminal_to_terminal_flag, er;
    logic codec_init_busy, audio_mute, pcm_in_valid, dac_valid, want_t2t, want_init;
    logic [2:0] want_code, c, r;
    logic [10:0] exp;
    int failures = 0;
    int check_count = 0;
    int n;
    rate_mode_control_decoder #(.NB_DIV_CYCLES(NB_DIV), .MUTE_CYCLES(26'h000_0028)) dut_u (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .action_time(action_time), .adc_raw(adc_raw),
        .decoded_sample(decoded_sample), .mode(mode), .narrowband(narrowband),
        .half_rate_ceiling_mode(half_rate_ceiling_mode),
        .terminal_to_terminal_flag(terminal_to_terminal_flag),
        .codec_init_busy(codec_init_busy), .audio_mute(audio_mute), .pcm_in(pcm_in),
        .pcm_in_valid(pcm_in_valid), .dac_sample(dac_sample), .dac_valid(dac_valid));
    ctrl_msg_sender sender_u (.clk(clk), .want_code(want_code), .want_t2t(want_t2t),
        .want_init(want_init), .fire(fire), .field(field), .action_time(action_time));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Model, bus and check tasks
    // ------------------------------------------------------------------
    function automatic logic [10:0] model(logic [2:0] k, logic t);
        return {k, 3'h0, t, k[1:0] == 2'h3, k[2], (k[1:0] == 2'h3) ? 2'h2 : k[1:0]};
    endfunction
    function automatic logic [15:0] widen(logic [15:0] s, int p);
        if (p == 1) return {s[13:0], 2'h0};
        if (p == 2) return {s[12:0], 3'h0};
        return s;
    endfunction
    task automatic results();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [2:0] k, input logic t, input logic i, input logic [2:0] rv);
        want_code = k;
        want_t2t = t;
        want_init = i;
        @(negedge clk);
        apb(1'b1, REG_CTRL_MSG, {24'h00_0000, field[7:5], rv, field[1:0]});
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic wait_tick();
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 4000) begin
                failures++;
                results();
            end
        end while (pcm_in_valid !== 1'b1);
    endtask
    task automatic bound(input int lim);
        if (n >= lim) begin
            failures++;
            results();
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, fire} = {1'b1, 44'h0};
        {adc_raw, decoded_sample, want_code, want_t2t, want_init} = 37'h0;
        n = $urandom(73795);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk({mode, narrowband, terminal_to_terminal_flag, codec_init_busy, audio_mute},
            0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        $display("test reset and map done");
        // Codes in shuffled order; reserved bits random, must not matter
        r = 3'($urandom);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i) ^ r;
            send(c, i[0], 1'b0, 3'($urandom));
            repeat (4) @(posedge clk);
            @(negedge clk);
            exp = model(c, i[0]);
            chk({terminal_to_terminal_flag, half_rate_ceiling_mode, narrowband, mode},
                exp[4:0]);
            apb(1'b0, REG_STATUS, 32'h0);
            chk(rd[10:0], exp);
        end
        $display("test codes done");
        // Nonzero decoded audio so that a missing mute shows
        decoded_sample <= 16'($urandom) | 16'h8000;
        for (int t = 0; t < 2; t++) begin
            send(3'h5, t[0], 1'b1, 3'h0);
            n = 0;
            while (codec_init_busy !== 1'b1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            bound(10);
            chk({mode, narrowband}, 3'h0);
            n = 0;
            while (codec_init_busy === 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            bound(100);
            chk(n, 17);
            chk({mode, narrowband}, 3'h3);
            chk({audio_mute, terminal_to_terminal_flag}, {t[0], t[0]});
            n = 0;
            while (audio_mute === 1'b1 && n < 100) begin
                // First cycle may still show a tick taken before mute rose
                if (dac_valid === 1'b1 && n > 0) chk(dac_sample, 16'h0000);
                @(negedge clk);
                n++;
            end
            bound(100);
            chk(n, t * 40);
        end
        $display("test init done");
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, REG_CONFIG, 32'(p));
            adc_raw <= 16'($urandom);
            decoded_sample <= 16'($urandom);
            wait_tick();
            wait_tick();
            chk(n, 32'(NB_DIV));
            chk(pcm_in, widen(adc_raw, p));
            chk(dac_sample, widen(decoded_sample, p));
        end
        send(3'h0, 1'b0, 1'b0, 3'h0);
        wait_tick();
        wait_tick();
        chk(n, 32'(WB_DIV_CYCLES));
        $display("test samples done");
        results();
    end
endmodule
